// >>> src/idw_consts.svh
// constants for the inter-domain window update and copy engine
`ifndef IDW_CONSTS_SVH
`define IDW_CONSTS_SVH

// ----------------------------------------
// operation codes and status codes
// ----------------------------------------
`define IDW_OP_UPDATE      8'h21
`define IDW_OP_COPY        8'h23
`define IDW_ST_NONE        8'h00
`define IDW_ST_OK          8'h01
`define IDW_ST_BAD_FLAGS   8'h10
`define IDW_ST_UNSUP_OP    8'h11
`define IDW_ST_PERM_FAULT  8'h1A

// ----------------------------------------
// descriptor field positions (bit lsb in the 512-bit word)
// ----------------------------------------
`define IDW_D_PASID_LSB    0
`define IDW_D_FLAGS_LSB    32
`define IDW_D_OP_LSB       56
`define IDW_D_CMPL_LSB     64
`define IDW_D_ADDR1_LSB    128
`define IDW_D_ADDR2_LSB    192
`define IDW_D_XFER_LSB     256
`define IDW_D_HANDA_LSB    480
`define IDW_D_WFLAG_LSB    488
`define IDW_D_HANDB_LSB    496

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define IDW_F_SRC_ALT      16
`define IDW_F_DST_ALT      17
`define IDW_F_SUPPRESS     16
`define IDW_W_READ         0
`define IDW_W_WRITE        1
`define IDW_W_ENABLE       2
`define IDW_W_OFFSET       3

// ----------------------------------------
// register byte offsets and fields
// ----------------------------------------
`define IDW_R_CAP          8'h00
`define IDW_R_IRQ_STAT     8'h04
`define IDW_R_IRQ_MASK     8'h08
`define IDW_R_ENG_STAT     8'h0C
`define IDW_R_TBL_IDX      8'h10
`define IDW_R_TBL_LOAD     8'h14
`define IDW_TBL_ALLOW_BIT  20
`define IDW_IRQ_OK         0
`define IDW_IRQ_ERR        1

`endif

// >>> src/idw_pkg.sv
// types shared by the inter-domain window engine
package idw_pkg;

  typedef enum logic [3:0] {
    IDLE, DECODE, UPD_RD, UPD_CHK, DRAIN, UPD_WR,
    SRC_RD, SRC_CHK, DST_RD, DST_CHK, CP_RD, CP_WR, CMPL
  } idw_state_t;

  typedef struct packed {
    logic [19:0] pasid;
    logic        allowUpdate;
    logic [3:0]  wflags;
    logic [63:0] base;
    logic [63:0] size;
  } idw_entry_t;

endpackage : idw_pkg

// >>> src/idw_tbl_if.sv
// port bundle between the engine and its permission table
`timescale 1ns/100ps
interface idw_tbl_if #(
  parameter int AW = 4,
  parameter int DW = 153
);
  logic          wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport eng (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : idw_tbl_if

// >>> src/idw_tbl_mem.sv
// permission table storage with registered read data
`timescale 1ns/100ps
module idw_tbl_mem #(
  parameter int DEPTH = 16,
  parameter int DW    = 153
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // table port
  idw_tbl_if.mem   tbl
);
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdData_q;

  // storage has no reset; software loads entries before use
  always_ff @(posedge clock) begin
    if (tbl.wrEn) begin
      mem[tbl.wrAddr] <= tbl.wrData;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= mem[tbl.rdAddr];
    end
  end

  assign tbl.rdData = rdData_q;
endmodule : idw_tbl_mem

// >>> src/idw_engine.sv
// inter-domain window update and cross-domain copy engine
//
// Notes on behaviour
// - opcode 0x21 atomically rewrites window attributes of the handle's table entry.
// - unless flag bit 16 is set, drain in-flight users before the update lands.
// - drain-suppress flag is reserved while its capability bit reads zero.
// - a window update inside a batch fails as unsupported operation.
// - window flag bit 3 picks address or offset mode; reserved when unusable.
// - window flag bit 2 turns range checking of incoming addresses on or off.
// - window flag bit 1 permits writes, bit 0 permits reads through the entry.
// - opcode 0x23 copies transfer-size bytes from source to destination.
// - copy accepts any byte alignment of addresses and size.
// - copy flag bit 17 makes the destination use the destination entry's id.
// - copy flag bit 16 makes the source use the source entry's id.
`include "idw_consts.svh"
`timescale 1ns/100ps
module idw_engine #(
  parameter int         DEPTH       = 16,
  parameter logic [0:0] OFFSET_SUPP = 1'h1,
  parameter logic [0:0] DRAIN_SUPP  = 1'h1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // descriptor submission
  input  wire logic         descValid,
  input  wire logic [511:0] descData,
  input  wire logic         descInBatch,
  output logic              descReady,
  // in-flight users of table entries, high while any remain
  input  wire logic         drainPending,
  // system memory, one byte per request, held until memAck
  output logic              memReq,
  output logic              memWrite,
  output logic [63:0]       memAddr,
  output logic [19:0]       memPasid,
  output logic [7:0]        memWdata,
  input  wire logic         memAck,
  input  wire logic [7:0]   memRdata,
  // register port
  input  wire logic [7:0]   regAddr,
  input  wire logic [31:0]  regWdata,
  input  wire logic         regWr,
  input  wire logic         regRd,
  output logic [31:0]       regRdata,
  // interrupt
  output logic              irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int DW = $bits(idw_pkg::idw_entry_t);

  generate
    if (DEPTH < 2 || DEPTH > 65536 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two between 2 and 65536");
    end
  endgenerate

  idw_tbl_if #(.AW(AW), .DW(DW)) tbl ();

  idw_tbl_mem #(.DEPTH(DEPTH), .DW(DW)) u_tbl (
    .clock (clock),
    .rstn  (rstn),
    .tbl   (tbl)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic rangeOk(idw_pkg::idw_entry_t e, logic [63:0] a, logic [31:0] n);
    logic [64:0] endA;
    endA = {1'h0, a} + {33'h0, n};
    if (!e.wflags[`IDW_W_ENABLE]) begin
      rangeOk = 1'h1;
    end else if (e.wflags[`IDW_W_OFFSET]) begin
      rangeOk = endA <= {1'h0, e.size};
    end else begin
      rangeOk = (a >= e.base) && (endA <= ({1'h0, e.base} + {1'h0, e.size}));
    end
  endfunction : rangeOk

  function automatic logic [63:0] physAddr(idw_pkg::idw_entry_t e, logic [63:0] a);
    physAddr = (e.wflags[`IDW_W_ENABLE] && e.wflags[`IDW_W_OFFSET]) ? e.base + a : a;
  endfunction : physAddr

  // ----------------------------------------
  // descriptor engine
  // ----------------------------------------
  idw_pkg::idw_state_t st_q, st_d;
  idw_pkg::idw_entry_t ent;
  logic [7:0]  op_q, op_d, status_q, status_d, byte_q, byte_d;
  logic [23:0] flags_q, flags_d;
  logic [19:0] pasid_q, pasid_d, srcPasid_q, srcPasid_d, dstPasid_q, dstPasid_d;
  logic [63:0] cmpl_q, cmpl_d, addr1_q, addr1_d, addr2_q, addr2_d;
  logic [31:0] xfer_q, xfer_d, idx_q, idx_d;
  logic [7:0]  wflag_q, wflag_d;
  logic [15:0] handA_q, handA_d, handB_q, handB_d;
  logic        batch_q, batch_d, evOk, evErr;
  logic        memReq_q, memReq_d, memWrite_q, memWrite_d, descReady_q, descReady_d;
  logic [63:0] memAddr_q, memAddr_d;
  logic [19:0] memPasid_q, memPasid_d;
  logic [7:0]  memWdata_q, memWdata_d;
  logic        offBad, supBad;

  assign ent = idw_pkg::idw_entry_t'(tbl.rdData);
  assign offBad = wflag_q[`IDW_W_OFFSET] && (!wflag_q[`IDW_W_ENABLE] || !OFFSET_SUPP);
  assign supBad = flags_q[`IDW_F_SUPPRESS] && !DRAIN_SUPP;

  always_comb begin
    st_d = st_q;        op_d = op_q;        status_d = status_q;  byte_d = byte_q;
    flags_d = flags_q;  pasid_d = pasid_q;  srcPasid_d = srcPasid_q;
    dstPasid_d = dstPasid_q;  cmpl_d = cmpl_q;  addr1_d = addr1_q;  addr2_d = addr2_q;
    xfer_d = xfer_q;    idx_d = idx_q;      wflag_d = wflag_q;
    handA_d = handA_q;  handB_d = handB_q;  batch_d = batch_q;
    evOk = 1'h0;
    evErr = 1'h0;
    unique case (st_q)
      idw_pkg::IDLE: begin
        if (descValid && descReady_q) begin
          op_d     = descData[`IDW_D_OP_LSB +: 8];
          flags_d  = descData[`IDW_D_FLAGS_LSB +: 24];
          pasid_d  = descData[`IDW_D_PASID_LSB +: 20];
          cmpl_d   = descData[`IDW_D_CMPL_LSB +: 64];
          addr1_d  = descData[`IDW_D_ADDR1_LSB +: 64];
          addr2_d  = descData[`IDW_D_ADDR2_LSB +: 64];
          xfer_d   = descData[`IDW_D_XFER_LSB +: 32];
          wflag_d  = descData[`IDW_D_WFLAG_LSB +: 8];
          handA_d  = descData[`IDW_D_HANDA_LSB +: 16];
          handB_d  = descData[`IDW_D_HANDB_LSB +: 16];
          batch_d  = descInBatch;
          status_d = `IDW_ST_NONE;
          idx_d    = '0;
          st_d     = idw_pkg::DECODE;
        end
      end
      idw_pkg::DECODE: begin
        st_d = idw_pkg::CMPL;
        srcPasid_d = pasid_q;
        dstPasid_d = pasid_q;
        if (op_q == `IDW_OP_UPDATE) begin
          if (batch_q) begin
            status_d = `IDW_ST_UNSUP_OP;
          end else if (offBad || supBad || wflag_q[7:4] != 4'h0) begin
            status_d = `IDW_ST_BAD_FLAGS;
          end else if (handB_q >= DEPTH) begin
            status_d = `IDW_ST_PERM_FAULT;
          end else begin
            st_d = idw_pkg::UPD_RD;
          end
        end else if (op_q == `IDW_OP_COPY) begin
          // no alignment test on any address or size
          if ((flags_q[`IDW_F_SRC_ALT] && handA_q >= DEPTH) ||
              (flags_q[`IDW_F_DST_ALT] && handB_q >= DEPTH)) begin
            status_d = `IDW_ST_PERM_FAULT;
          end else if (flags_q[`IDW_F_SRC_ALT]) begin
            st_d = idw_pkg::SRC_RD;
          end else if (flags_q[`IDW_F_DST_ALT]) begin
            st_d = idw_pkg::DST_RD;
          end else begin
            st_d = (xfer_q == 32'h0) ? idw_pkg::CMPL : idw_pkg::CP_RD;
            status_d = (xfer_q == 32'h0) ? `IDW_ST_OK : `IDW_ST_NONE;
          end
        end else begin
          status_d = `IDW_ST_UNSUP_OP;
        end
      end
      idw_pkg::UPD_RD: st_d = idw_pkg::UPD_CHK;
      idw_pkg::UPD_CHK: begin
        if (ent.pasid != pasid_q || !ent.allowUpdate) begin
          status_d = `IDW_ST_PERM_FAULT;
          st_d     = idw_pkg::CMPL;
        end else begin
          st_d = flags_q[`IDW_F_SUPPRESS] ? idw_pkg::UPD_WR : idw_pkg::DRAIN;
        end
      end
      idw_pkg::DRAIN: if (!drainPending) st_d = idw_pkg::UPD_WR;
      idw_pkg::UPD_WR: begin
        status_d = `IDW_ST_OK;
        st_d     = idw_pkg::CMPL;
      end
      idw_pkg::SRC_RD: st_d = idw_pkg::SRC_CHK;
      idw_pkg::DST_RD: st_d = idw_pkg::DST_CHK;
      idw_pkg::SRC_CHK, idw_pkg::DST_CHK: begin
        if (st_q == idw_pkg::SRC_CHK ? (!ent.wflags[`IDW_W_READ] || !rangeOk(ent, addr1_q, xfer_q))
                                     : (!ent.wflags[`IDW_W_WRITE] || !rangeOk(ent, addr2_q, xfer_q))) begin
          status_d = `IDW_ST_PERM_FAULT;
          st_d     = idw_pkg::CMPL;
        end else begin
          if (st_q == idw_pkg::SRC_CHK) begin
            srcPasid_d = ent.pasid;
            addr1_d    = physAddr(ent, addr1_q);
          end else begin
            dstPasid_d = ent.pasid;
            addr2_d    = physAddr(ent, addr2_q);
          end
          if (st_q == idw_pkg::SRC_CHK && flags_q[`IDW_F_DST_ALT]) begin
            st_d = idw_pkg::DST_RD;
          end else if (xfer_q == 32'h0) begin
            status_d = `IDW_ST_OK;
            st_d     = idw_pkg::CMPL;
          end else begin
            st_d = idw_pkg::CP_RD;
          end
        end
      end
      idw_pkg::CP_RD: begin
        if (memAck) begin
          byte_d = memRdata;
          st_d   = idw_pkg::CP_WR;
        end
      end
      idw_pkg::CP_WR: begin
        if (memAck) begin
          idx_d = idx_q + 32'h1;
          if (idx_d == xfer_q) begin
            status_d = `IDW_ST_OK;
            st_d     = idw_pkg::CMPL;
          end else begin
            st_d = idw_pkg::CP_RD;
          end
        end
      end
      idw_pkg::CMPL: begin
        if (memAck) begin
          evOk  = status_q == `IDW_ST_OK;
          evErr = status_q != `IDW_ST_OK;
          st_d  = idw_pkg::IDLE;
        end
      end
    endcase
    // memory request follows the state being entered, so it is valid in the same cycle as the state register
    memReq_d    = st_d inside {idw_pkg::CP_RD, idw_pkg::CP_WR, idw_pkg::CMPL};
    memWrite_d  = st_d != idw_pkg::CP_RD;
    memAddr_d   = (st_d == idw_pkg::CMPL) ? cmpl_d :
                  (st_d == idw_pkg::CP_RD) ? addr1_d + {32'h0, idx_d} : addr2_d + {32'h0, idx_d};
    memPasid_d  = (st_d == idw_pkg::CP_RD) ? srcPasid_d :
                  (st_d == idw_pkg::CP_WR) ? dstPasid_d : pasid_d;
    memWdata_d  = (st_d == idw_pkg::CMPL) ? status_d : byte_d;
    descReady_d = st_d == idw_pkg::IDLE;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= idw_pkg::IDLE;  op_q <= '0;  status_q <= '0;  byte_q <= '0;  flags_q <= '0;
      pasid_q <= '0;  srcPasid_q <= '0;  dstPasid_q <= '0;  cmpl_q <= '0;  addr1_q <= '0;
      addr2_q <= '0;  xfer_q <= '0;  idx_q <= '0;  wflag_q <= '0;  handA_q <= '0;
      handB_q <= '0;  batch_q <= 1'h0;  memReq_q <= 1'h0;  memWrite_q <= 1'h0;
      memAddr_q <= '0;  memPasid_q <= '0;  memWdata_q <= '0;  descReady_q <= 1'h0;
    end else begin
      st_q <= st_d;  op_q <= op_d;  status_q <= status_d;  byte_q <= byte_d;  flags_q <= flags_d;
      pasid_q <= pasid_d;  srcPasid_q <= srcPasid_d;  dstPasid_q <= dstPasid_d;  cmpl_q <= cmpl_d;
      addr1_q <= addr1_d;  addr2_q <= addr2_d;  xfer_q <= xfer_d;  idx_q <= idx_d;
      wflag_q <= wflag_d;  handA_q <= handA_d;  handB_q <= handB_d;  batch_q <= batch_d;
      memReq_q <= memReq_d;  memWrite_q <= memWrite_d;  memAddr_q <= memAddr_d;
      memPasid_q <= memPasid_d;  memWdata_q <= memWdata_d;  descReady_q <= descReady_d;
    end
  end

  // ----------------------------------------
  // permission table access
  // ----------------------------------------
  logic [AW-1:0] tblIdx_q, tblIdx_d;
  logic          busLoad;

  assign busLoad = regWr && regAddr == `IDW_R_TBL_LOAD;
  // the engine's update takes the write port whole in one cycle, which keeps it atomic;
  // a software load in that same cycle is dropped
  assign tbl.wrEn   = (st_q == idw_pkg::UPD_WR) || busLoad;
  assign tbl.wrAddr = (st_q == idw_pkg::UPD_WR) ? handB_q[AW-1:0] : tblIdx_q;
  assign tbl.wrData = (st_q == idw_pkg::UPD_WR) ?
                      {ent.pasid, ent.allowUpdate, wflag_q[3:0], addr1_q, addr2_q} :
                      {regWdata[19:0], regWdata[`IDW_TBL_ALLOW_BIT], 4'h0, 64'h0, 64'h0};
  assign tbl.rdAddr = (st_q == idw_pkg::SRC_RD) ? handA_q[AW-1:0] : handB_q[AW-1:0];

  // ----------------------------------------
  // register port and interrupt
  // ----------------------------------------
  logic [1:0]  irqStat_q, irqStat_d, irqMask_q, irqMask_d;
  logic [31:0] regRdata_q, regRdata_d;
  logic        irq_q, irq_d;

  always_comb begin
    irqMask_d  = irqMask_q;
    tblIdx_d   = tblIdx_q;
    regRdata_d = 32'h0;
    if (regWr && regAddr == `IDW_R_IRQ_MASK) irqMask_d = regWdata[1:0];
    if (regWr && regAddr == `IDW_R_TBL_IDX) tblIdx_d = regWdata[AW-1:0];
    if (regRd) begin
      unique case (regAddr)
        `IDW_R_CAP:      regRdata_d = {30'h0, DRAIN_SUPP, OFFSET_SUPP};
        `IDW_R_IRQ_STAT: regRdata_d = {30'h0, irqStat_q};
        `IDW_R_IRQ_MASK: regRdata_d = {30'h0, irqMask_q};
        `IDW_R_ENG_STAT: regRdata_d = {16'h0, status_q, 7'h0, st_q != idw_pkg::IDLE};
        `IDW_R_TBL_IDX:  regRdata_d = 32'(tblIdx_q);
        default:         regRdata_d = 32'h0;
      endcase
    end
    // a new event in the clearing read's cycle survives
    irqStat_d = ((regRd && regAddr == `IDW_R_IRQ_STAT) ? 2'h0 : irqStat_q) | {evErr, evOk};
    irq_d     = |(irqStat_d & irqMask_d);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irqStat_q  <= '0;
      irqMask_q  <= '0;
      tblIdx_q   <= '0;
      regRdata_q <= '0;
      irq_q      <= 1'h0;
    end else begin
      irqStat_q  <= irqStat_d;
      irqMask_q  <= irqMask_d;
      tblIdx_q   <= tblIdx_d;
      regRdata_q <= regRdata_d;
      irq_q      <= irq_d;
    end
  end

  assign descReady = descReady_q;
  assign memReq    = memReq_q;
  assign memWrite  = memWrite_q;
  assign memAddr   = memAddr_q;
  assign memPasid  = memPasid_q;
  assign memWdata  = memWdata_q;
  assign regRdata  = regRdata_q;
  assign irq       = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  update_write_a: assert property (st_q == idw_pkg::UPD_WR |=> st_q == idw_pkg::CMPL && status_q == `IDW_ST_OK)
    else $error("window update did not complete with success");
  drain_hold_a: assert property (st_q == idw_pkg::DRAIN && drainPending |=> st_q == idw_pkg::DRAIN)
    else $error("update left drain while users were in flight");
  drain_skip_a: assert property (st_q == idw_pkg::UPD_CHK && flags_q[`IDW_F_SUPPRESS] |=> st_q != idw_pkg::DRAIN)
    else $error("drain performed although suppressed");
  suppress_cap_a: assert property (st_q == idw_pkg::DECODE && op_q == `IDW_OP_UPDATE && !batch_q && supBad
    |=> status_q == `IDW_ST_BAD_FLAGS)
    else $error("reserved suppress flag accepted");
  batch_reject_a: assert property (st_q == idw_pkg::DECODE && op_q == `IDW_OP_UPDATE && batch_q
    |=> st_q == idw_pkg::CMPL && status_q == `IDW_ST_UNSUP_OP)
    else $error("batched window update not rejected");
  mode_reserved_a: assert property (st_q == idw_pkg::DECODE && op_q == `IDW_OP_UPDATE && !batch_q && offBad
    |=> status_q == `IDW_ST_BAD_FLAGS)
    else $error("reserved window mode accepted");
  write_perm_a: assert property (st_q == idw_pkg::DST_CHK && !ent.wflags[`IDW_W_WRITE]
    |=> status_q == `IDW_ST_PERM_FAULT)
    else $error("destination written without write permission");
  copy_count_a: assert property (st_q == idw_pkg::CP_WR && memAck && idx_q + 32'h1 == xfer_q
    |=> st_q == idw_pkg::CMPL ##0 idx_q == xfer_q)
    else $error("copy byte count wrong");
  dst_pasid_a: assert property (memReq_q && st_q == idw_pkg::CP_WR |-> memPasid_q == dstPasid_q)
    else $error("destination access used wrong address space");
  cmpl_write_a: assert property (memReq_q && st_q == idw_pkg::CMPL
    |-> memWrite_q && memAddr_q == cmpl_q && memWdata_q == status_q)
    else $error("completion record write malformed");
endmodule : idw_engine

// >>> testbench/idw_mem_model.sv
// behavioural system memory answering the engine's byte requests
`timescale 1ns/100ps
module idw_mem_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // byte request port
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [63:0] memAddr,
  input  wire logic [19:0] memPasid,
  input  wire logic [7:0]  memWdata,
  input  wire logic        slow,
  output logic             memAck,
  output logic [7:0]       memRdata
);
  logic [7:0]  mem [256];
  logic [19:0] pasOf [256];
  logic [19:0] rdPas;
  int          waitCnt;
  // outside an ack the read data toggles, so a late sample is caught
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memAck   <= 1'h0;
      waitCnt  <= 0;
      memRdata <= 8'h5A;
    end else begin
      memAck   <= 1'h0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
        if (waitCnt < (slow ? 3 : 0)) begin
          waitCnt <= waitCnt + 1;
        end else begin
          waitCnt <= 0;
          memAck  <= 1'h1;
          if (memWrite) begin
            mem[memAddr[7:0]]   <= memWdata;
            pasOf[memAddr[7:0]] <= memPasid;
          end else begin
            memRdata <= mem[memAddr[7:0]];
            rdPas    <= memPasid;
          end
        end
      end
    end
  end
endmodule : idw_mem_model

// >>> testbench/inter_domain_window_copy_tb.sv
// self-checking bench for the window update and cross-domain copy engine
`timescale 1ns/100ps
module inter_domain_window_copy_tb;
  logic         clock = 1'h0;
  logic         rstn, descValid, descInBatch, descReady, drainPending, slow;
  logic [511:0] descData;
  logic         memReq, memWrite, memAck, regWr, regRd, irq;
  logic [63:0]  memAddr;
  logic [19:0]  memPasid;
  logic [7:0]   memWdata, memRdata, regAddr;
  logic [31:0]  regWdata, regRdata;
  int           num_errors = 0;
  int           total_checks = 0;
  logic         nsReq, nsWrite, nsAck;
  logic [63:0]  nsAddr;
  logic [19:0]  nsPasid;
  logic [7:0]   nsWdata, nsRdata;

  always #12.5 clock = ~clock;

  idw_engine idw_engine_inst (.clock, .rstn, .descValid, .descData, .descInBatch, .descReady, .drainPending,
    .memReq, .memWrite, .memAddr, .memPasid, .memWdata, .memAck, .memRdata,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq);
  idw_mem_model idw_mem_model_inst (.clock, .rstn, .memReq, .memWrite, .memAddr, .memPasid, .memWdata,
    .slow, .memAck, .memRdata);
  // second engine without drain-suppress support shares all stimulus; only its completion byte is judged
  idw_engine #(.DRAIN_SUPP(1'h0)) idw_engine_inst_ns (.clock, .rstn, .descValid, .descData, .descInBatch,
    .descReady(), .drainPending, .memReq(nsReq), .memWrite(nsWrite), .memAddr(nsAddr),
    .memPasid(nsPasid), .memWdata(nsWdata), .memAck(nsAck), .memRdata(nsRdata),
    .regAddr, .regWdata, .regWr, .regRd, .regRdata(), .irq());
  idw_mem_model idw_mem_model_inst_ns (.clock, .rstn, .memReq(nsReq), .memWrite(nsWrite), .memAddr(nsAddr),
    .memPasid(nsPasid), .memWdata(nsWdata), .slow, .memAck(nsAck), .memRdata(nsRdata));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clock);
    regWr <= 1'h0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clock);
    regRd <= 1'h0;
    @(posedge clock);
    chkWord(regRdata, exp);
  endtask : rd

  // completion record always at 0xF0, so the status byte is read back from there
  function automatic logic [511:0] mk(input logic [7:0] op, input logic [23:0] fl, input logic [19:0] pas,
    input logic [7:0] a1, input logic [7:0] a2, input logic [7:0] x, input logic [15:0] hA, input logic [15:0] hB);
    mk = {hB, hA, 216'h0, x, 56'h0, a2, 56'h0, a1, 56'h0, 8'hF0, op, fl, 12'h0, pas};
  endfunction : mk

  task automatic run(input logic [511:0] d, input logic b, input logic [7:0] exp);
    int n;
    idw_mem_model_inst.mem[8'hF0] = 8'h00;
    descData <= d;
    descInBatch <= b;
    descValid <= 1'h1;
    @(posedge clock);
    n = 0;
    while (descReady !== 1'h1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    descValid <= 1'h0;
    if (n >= 50) num_errors++;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (descReady !== 1'h1 && n < 400);
    if (n >= 400) num_errors++;
    chkByte(idw_mem_model_inst.mem[8'hF0], exp);
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(8'h00, 32'h0000_0003);
    wr(8'h08, 32'h0000_0001);
    rd(8'h08, 32'h0000_0001);
    rd(8'h18, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0010_0011);
    wr(8'h10, 32'h0000_0001);
    wr(8'h14, 32'h0000_0022);
    wr(8'h10, 32'h0000_0002);
    wr(8'h14, 32'h0010_0033);
    $display("test regs done");
  endtask : t_regs

  task automatic t_update;
    run(mk(8'h21, 24'h01_0000, 20'h0_0011, 8'h40, 8'h40, 8'h00, 16'h0700, 16'h0000), 1'h0, 8'h01);
    chkByte(idw_mem_model_inst_ns.mem[8'hF0], 8'h10);
    @(posedge clock);
    chkWord({31'h0, irq}, 32'h0000_0001);
    rd(8'h04, 32'h0000_0001);
    @(posedge clock);
    chkWord({31'h0, irq}, 32'h0000_0000);
    $display("test update done");
  endtask : t_update

  task automatic t_drain;
    drainPending <= 1'h1;
    fork
      run(mk(8'h21, 24'h00_0000, 20'h0_0033, 8'h00, 8'h00, 8'h00, 16'h0200, 16'h0002), 1'h0, 8'h01);
      begin
        repeat (20) @(posedge clock);
        chkByte(idw_mem_model_inst.mem[8'hF0], 8'h00);
        drainPending <= 1'h0;
      end
    join
    $display("test drain done");
  endtask : t_drain

  task automatic t_reject;
    run(mk(8'h21, 24'h01_0000, 20'h0_0011, 8'h40, 8'h40, 8'h00, 16'h0700, 16'h0000), 1'h1, 8'h11);
    rd(8'h0C, 32'h0000_1100);
    run(mk(8'h21, 24'h01_0000, 20'h0_0011, 8'h00, 8'h00, 8'h00, 16'h0800, 16'h0000), 1'h0, 8'h10);
    run(mk(8'h21, 24'h01_0000, 20'h0_0011, 8'h40, 8'h40, 8'h00, 16'h1700, 16'h0000), 1'h0, 8'h10);
    rd(8'h04, 32'h0000_0003);
    chkWord({31'h0, irq}, 32'h0000_0000);
    $display("test reject done");
  endtask : t_reject

  task automatic t_copy;
    slow <= 1'h1;
    run(mk(8'h23, 24'h01_0000, 20'h0_0055, 8'h43, 8'h91, 8'h03, 16'h0000, 16'h0001), 1'h0, 8'h01);
    for (int i = 0; i < 3; i++) begin
      chkByte(idw_mem_model_inst.mem[8'h91 + i], 8'(8'h43 + i) ^ 8'hA5);
    end
    chkWord({12'h0, idw_mem_model_inst.pasOf[8'h91]}, 32'h0000_0055);
    chkWord({12'h0, idw_mem_model_inst.rdPas}, 32'h0000_0011);
    slow <= 1'h0;
    run(mk(8'h23, 24'h01_0000, 20'h0_0055, 8'h7F, 8'hA0, 8'h02, 16'h0000, 16'h0000), 1'h0, 8'h1A);
    run(mk(8'h23, 24'h02_0000, 20'h0_0055, 8'h50, 8'hC8, 8'h01, 16'h0000, 16'h0002), 1'h0, 8'h01);
    chkWord({12'h0, idw_mem_model_inst.pasOf[8'hC8]}, 32'h0000_0033);
    run(mk(8'h23, 24'h01_0000, 20'h0_0055, 8'h50, 8'hC8, 8'h01, 16'h0002, 16'h0000), 1'h0, 8'h1A);
    $display("test copy done");
  endtask : t_copy

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  initial begin
    rstn = 1'h0;
    {descValid, descInBatch, drainPending, regWr, regRd, slow} = 6'h00;
    descData = '0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    for (int i = 0; i < 256; i++) idw_mem_model_inst.mem[i] = 8'(i) ^ 8'hA5;
    repeat (6) @(posedge clock);
    rstn <= 1'h1;
    repeat (2) @(posedge clock);
    t_regs;
    t_update;
    t_drain;
    t_reject;
    t_copy;
    complete_run;
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run;
  end
endmodule : inter_domain_window_copy_tb
